// ==== include/pfps_pkg.sv ====
package pfps_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [7:0] PFPS_IDX_SNS_THIRD = 8'hD5;
  localparam logic [7:0] PFPS_IDX_SNS_UPPER = 8'hD6;
  localparam logic [7:0] PFPS_IDX_ADC_LOW = 8'hD9;
  localparam logic [7:0] PFPS_IDX_ADC_MID = 8'hDA;
  localparam logic [7:0] PFPS_IDX_ADC_HIGH = 8'hDB;
  localparam logic [7:0] PFPS_IDX_ADC_TOP = 8'hDC;
  localparam logic [7:0] PFPS_IDX_PU_A = 8'hDD;
  localparam logic [7:0] PFPS_IDX_PU_B = 8'hDE;
  localparam logic [7:0] PFPS_IDX_PU_C = 8'hDF;

  // Storage slots
  localparam int PFPS_NREG = 9;
  localparam logic [3:0] PFPS_SLOT_SNS_THIRD = 4'h0;
  localparam logic [3:0] PFPS_SLOT_SNS_UPPER = 4'h1;
  localparam logic [3:0] PFPS_SLOT_ADC_LOW = 4'h2;
  localparam logic [3:0] PFPS_SLOT_ADC_MID = 4'h3;
  localparam logic [3:0] PFPS_SLOT_ADC_HIGH = 4'h4;
  localparam logic [3:0] PFPS_SLOT_ADC_TOP = 4'h5;
  localparam logic [3:0] PFPS_SLOT_PU_A = 4'h6;
  localparam logic [3:0] PFPS_SLOT_PU_B = 4'h7;
  localparam logic [3:0] PFPS_SLOT_PU_C = 4'h8;

  localparam logic [PFPS_NREG-1:0][7:0] PFPS_IDX_TAB = {
    PFPS_IDX_PU_C, PFPS_IDX_PU_B, PFPS_IDX_PU_A, PFPS_IDX_ADC_TOP, PFPS_IDX_ADC_HIGH,
    PFPS_IDX_ADC_MID, PFPS_IDX_ADC_LOW, PFPS_IDX_SNS_UPPER, PFPS_IDX_SNS_THIRD};

  // Implemented bits of each register
  localparam logic [7:0] PFPS_MASK_FULL = 8'hFF;
  localparam logic [7:0] PFPS_MASK_PAIR = 8'h03;
  localparam logic [PFPS_NREG-1:0][7:0] PFPS_MASK_TAB = {
    PFPS_MASK_FULL, PFPS_MASK_FULL, PFPS_MASK_PAIR, PFPS_MASK_PAIR, PFPS_MASK_FULL,
    PFPS_MASK_FULL, PFPS_MASK_FULL, PFPS_MASK_PAIR, PFPS_MASK_FULL};

  // Reset values
  localparam logic [7:0] PFPS_RST_SNS_THIRD = 8'h00;
  localparam logic [7:0] PFPS_RST_SNS_UPPER = 8'h00;
  localparam logic [7:0] PFPS_RST_ADC_LOW = 8'h00;
  localparam logic [7:0] PFPS_RST_ADC_MID = 8'h00;
  localparam logic [7:0] PFPS_RST_ADC_HIGH = 8'h00;
  localparam logic [7:0] PFPS_RST_ADC_TOP = 8'h00;
  localparam logic [7:0] PFPS_RST_PU_A = 8'h00;
  localparam logic [7:0] PFPS_RST_PU_B = 8'h00;
  localparam logic [7:0] PFPS_RST_PU_C = 8'h00;
  localparam logic [PFPS_NREG-1:0][7:0] PFPS_RST_TAB = {
    PFPS_RST_PU_C, PFPS_RST_PU_B, PFPS_RST_PU_A, PFPS_RST_ADC_TOP, PFPS_RST_ADC_HIGH,
    PFPS_RST_ADC_MID, PFPS_RST_ADC_LOW, PFPS_RST_SNS_UPPER, PFPS_RST_SNS_THIRD};

  // AXI responses
  localparam logic [1:0] PFPS_RESP_OKAY = 2'h0;
  localparam logic [1:0] PFPS_RESP_SLVERR = 2'h2;

  // Pad and analog-switch controls
  typedef struct packed {
    logic [9:0] sensor_route;
    logic [25:0] analog_route;
    logic [1:0] port_a_pullup;
    logic [7:0] port_b_pullup;
    logic [7:0] port_c_pullup;
  } pfps_pad_ctrl_t;

  typedef struct packed {
    logic [PFPS_NREG-1:0][7:0] regs;
    logic aw_rdy;
    logic w_rdy;
    logic aw_got;
    logic w_got;
    logic wr_hit;
    logic [3:0] wr_slot;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic rd_hit;
    logic [3:0] rd_slot;
  } pfps_state_t;

endpackage

// ==== rtl/pfps_top.sv ====
// Overview of operation
// R01: Third sensor register bits select channels 16-23
// R02: Sensor bit one routes pin to sensing
// R03: Upper sensor register bits 1:0 select 24,25
// R04: Analog bit one gives pin to converter
// R05: Analog low/high registers map inputs 0-7, 16-23
// R06: Analog mid register maps inputs 8-15
// R07: Analog top register bits 1:0 select 24,25
// R08: Port A pull-up: two bits, one pin each
// R09: Port B pull-up: eight bits, one pin each
// R10: Port C pull-up: eight bits, one pin each
// R11: Unused bits read zero; selects act independently
//
// Implementation choice: the AXI4-Lite interface to the registers.
module pfps_top
  import pfps_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic [2:0] s_axi_awprot_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic [2:0] s_axi_arprot_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output pfps_pad_ctrl_t pad_ctrl_o
);

  generate
    if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr_w
      $error("ADDR_W must lie between 10 and 32");
    end
  endgenerate

  pfps_state_t st;
  pfps_state_t next_st;

  // Address decode, shared by read and write paths
  function automatic logic [4:0] decode_slot(input logic [ADDR_W-1:0] addr);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 0; i < PFPS_NREG; i++) begin
      if (addr == ADDR_W'({PFPS_IDX_TAB[i], 2'b00})) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction

  logic [4:0] aw_dec;
  logic [4:0] ar_dec;

  always_comb begin
    aw_dec = decode_slot(s_axi_awaddr_i);
    ar_dec = decode_slot(s_axi_araddr_i);
  end

  always_comb begin
    next_st = st;
    // Address and data are taken independently, in either order
    if (s_axi_awvalid_i && st.aw_rdy) begin
      next_st.aw_got = 1'b1;
      next_st.aw_rdy = 1'b0;
      next_st.wr_hit = aw_dec[4];
      next_st.wr_slot = aw_dec[3:0];
    end
    if (s_axi_wvalid_i && st.w_rdy) begin
      next_st.w_got = 1'b1;
      next_st.w_rdy = 1'b0;
      next_st.wdata = s_axi_wdata_i;
      next_st.wstrb = s_axi_wstrb_i;
    end
    if (next_st.aw_got && next_st.w_got && !st.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = next_st.wr_hit ? PFPS_RESP_OKAY : PFPS_RESP_SLVERR;
      // Only lane 0 carries register data; unimplemented bits never store
      if (next_st.wr_hit && next_st.wstrb[0]) begin
        next_st.regs[next_st.wr_slot] = next_st.wdata[7:0] & PFPS_MASK_TAB[next_st.wr_slot]; // R11
      end
    end
    // Channels stay closed until the response is taken: one write at a time
    if (st.bvalid && s_axi_bready_i) begin
      next_st.bvalid = 1'b0;
      next_st.aw_rdy = 1'b1;
      next_st.w_rdy = 1'b1;
    end
    if (s_axi_arvalid_i && st.ar_rdy) begin
      next_st.ar_rdy = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rd_hit = ar_dec[4];
      next_st.rd_slot = ar_dec[3:0];
      next_st.rresp = ar_dec[4] ? PFPS_RESP_OKAY : PFPS_RESP_SLVERR;
      next_st.rdata = ar_dec[4] ? {24'h000000, st.regs[ar_dec[3:0]] & PFPS_MASK_TAB[ar_dec[3:0]]} : 32'h00000000; // R11
    end
    if (st.rvalid && s_axi_rready_i) begin
      next_st.rvalid = 1'b0;
      next_st.ar_rdy = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '0;
      st.regs <= PFPS_RST_TAB;
      st.aw_rdy <= 1'b1;
      st.w_rdy <= 1'b1;
      st.ar_rdy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    s_axi_awready_o = st.aw_rdy;
    s_axi_wready_o = st.w_rdy;
    s_axi_bvalid_o = st.bvalid;
    s_axi_bresp_o = st.bresp;
    s_axi_arready_o = st.ar_rdy;
    s_axi_rvalid_o = st.rvalid;
    s_axi_rresp_o = st.rresp;
    s_axi_rdata_o = st.rdata;
  end

  // Each control bit drives its own switch; several may be on at once
  always_comb begin
    pad_ctrl_o.sensor_route = {st.regs[PFPS_SLOT_SNS_UPPER][1:0], st.regs[PFPS_SLOT_SNS_THIRD]}; // R01 R02 R03
    pad_ctrl_o.analog_route = {st.regs[PFPS_SLOT_ADC_TOP][1:0], st.regs[PFPS_SLOT_ADC_HIGH],
                               st.regs[PFPS_SLOT_ADC_MID], st.regs[PFPS_SLOT_ADC_LOW]}; // R04 R05 R06 R07
    pad_ctrl_o.port_a_pullup = st.regs[PFPS_SLOT_PU_A][1:0]; // R08
    pad_ctrl_o.port_b_pullup = st.regs[PFPS_SLOT_PU_B]; // R09
    pad_ctrl_o.port_c_pullup = st.regs[PFPS_SLOT_PU_C]; // R10
  end

  sequence s_write_done(logic [3:0] slot);
    $rose(st.bvalid) && st.wr_hit && st.wr_slot == slot && st.wstrb[0];
  endsequence

  sequence s_read_done(logic [3:0] slot);
    $rose(st.rvalid) && st.rd_hit && st.rd_slot == slot;
  endsequence

  AST_SNS_THIRD_WRITE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R01
    s_write_done(PFPS_SLOT_SNS_THIRD) |-> pad_ctrl_o.sensor_route[7:0] == st.wdata[7:0])
    else $error("sensor channels 16-23 do not follow the written byte");

  AST_SNS_HOLD: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R02
    !$rose(st.bvalid) |-> $stable(pad_ctrl_o.sensor_route))
    else $error("sensor routing changed without a write");

  AST_SNS_UPPER_WRITE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R03
    s_write_done(PFPS_SLOT_SNS_UPPER) |-> pad_ctrl_o.sensor_route[9:8] == st.wdata[1:0])
    else $error("sensor channels 24-25 do not follow the written pair");

  AST_ADC_HOLD: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R04
    !$rose(st.bvalid) |-> $stable(pad_ctrl_o.analog_route))
    else $error("analog routing changed without a write");

  AST_ADC_LOW_HIGH: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R05
    s_write_done(PFPS_SLOT_ADC_LOW) or s_write_done(PFPS_SLOT_ADC_HIGH) |->
      (st.wr_slot == PFPS_SLOT_ADC_LOW ? pad_ctrl_o.analog_route[7:0] : pad_ctrl_o.analog_route[23:16])
        == st.wdata[7:0])
    else $error("analog inputs 0-7 or 16-23 do not follow the written byte");

  AST_ADC_MID: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R06
    s_write_done(PFPS_SLOT_ADC_MID) |-> pad_ctrl_o.analog_route[15:8] == st.wdata[7:0])
    else $error("analog inputs 8-15 do not follow the written byte");

  AST_ADC_TOP: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R07
    s_write_done(PFPS_SLOT_ADC_TOP) |-> pad_ctrl_o.analog_route[25:24] == st.wdata[1:0])
    else $error("analog inputs 24-25 do not follow the written pair");

  AST_PU_A: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R08
    s_write_done(PFPS_SLOT_PU_A) |-> pad_ctrl_o.port_a_pullup == st.wdata[1:0])
    else $error("port A pull-ups do not follow the written pair");

  AST_PU_B: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R09
    s_write_done(PFPS_SLOT_PU_B) |-> pad_ctrl_o.port_b_pullup == st.wdata[7:0])
    else $error("port B pull-ups do not follow the written byte");

  AST_PU_C: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R10
    s_write_done(PFPS_SLOT_PU_C) |-> pad_ctrl_o.port_c_pullup == st.wdata[7:0])
    else $error("port C pull-ups do not follow the written byte");

  AST_PAIR_READ_ZERO: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R11
    s_read_done(PFPS_SLOT_SNS_UPPER) or s_read_done(PFPS_SLOT_ADC_TOP) or s_read_done(PFPS_SLOT_PU_A)
      |-> s_axi_rdata_o[31:2] == 30'h00000000)
    else $error("unused bits of a two-bit register read nonzero");

  AST_BAD_ADDR: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    $rose(st.bvalid) && !st.wr_hit |-> s_axi_bresp_o == PFPS_RESP_SLVERR && $stable(st.regs))
    else $error("unmapped write not refused");

  sequence s_aw_take;
    s_axi_awvalid_i && s_axi_awready_o;
  endsequence

  sequence s_w_take;
    s_axi_wvalid_i && s_axi_wready_o;
  endsequence

  // Both halves of a write are in hand once each was taken now or earlier
  sequence s_write_lands;
    (s_axi_awvalid_i && s_axi_awready_o || st.aw_got) && (s_axi_wvalid_i && s_axi_wready_o || st.w_got);
  endsequence

  sequence s_b_done;
    s_axi_bvalid_o && s_axi_bready_i;
  endsequence

  sequence s_ar_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence

  sequence s_ar_hit;
    s_axi_arvalid_i && s_axi_arready_o && ar_dec[4];
  endsequence

  sequence s_ar_miss;
    s_axi_arvalid_i && s_axi_arready_o && !ar_dec[4];
  endsequence

  sequence s_r_done;
    s_axi_rvalid_o && s_axi_rready_i;
  endsequence

  AST_AW_ONCE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_aw_take |=> !s_axi_awready_o)
    else $error("write address channel reopened right after a take");

  AST_W_ONCE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_w_take |=> !s_axi_wready_o)
    else $error("write data channel reopened right after a take");

  AST_WRITE_ANSWER: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_write_lands |=> s_axi_bvalid_o)
    else $error("write response missing one cycle after both halves");

  AST_B_HOLD: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped or changed before it was taken");

  AST_B_RELEASE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_b_done |=> !s_axi_bvalid_o && s_axi_awready_o && s_axi_wready_o)
    else $error("write channels not reopened after the response");

  AST_W_CLOSED: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write channels open while a response is pending");

  AST_WRITE_OKAY: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    $rose(st.bvalid) && st.wr_hit |-> s_axi_bresp_o == PFPS_RESP_OKAY)
    else $error("mapped write not answered okay");

  AST_NO_STROBE_KEEP: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    $rose(st.bvalid) && !st.wstrb[0] |-> $stable(st.regs))
    else $error("write without lane 0 strobe changed a register");

  AST_READ_ANSWER: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_ar_take |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read data missing one cycle after the address");

  AST_R_HOLD: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_axi_rvalid_o && !s_axi_rready_i |=>
      s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
    else $error("read data dropped or changed before it was taken");

  AST_R_RELEASE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_r_done |=> !s_axi_rvalid_o && s_axi_arready_o)
    else $error("read address channel not reopened after the data");

  AST_AR_CLOSED: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read address channel open while data is pending");

  AST_READ_REFUSE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_ar_miss |=> s_axi_rresp_o == PFPS_RESP_SLVERR && s_axi_rdata_o == 32'h00000000)
    else $error("unmapped read not refused with zero data");

  AST_READ_OKAY: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R11
    s_ar_hit |=> s_axi_rresp_o == PFPS_RESP_OKAY && s_axi_rdata_o[31:8] == 24'h000000)
    else $error("mapped read not okay or upper lanes nonzero");

  // Stored bytes never hold unused bits, so the raw slot is the expected data
  AST_READ_VALUE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R11
    s_ar_hit |=> s_axi_rdata_o[7:0] == $past(st.regs[ar_dec[3:0]]))
    else $error("read data differs from the register at the take");

  AST_PAIR_UNUSED: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R11
    st.regs[PFPS_SLOT_SNS_UPPER][7:2] == 6'h00 && st.regs[PFPS_SLOT_ADC_TOP][7:2] == 6'h00 &&
      st.regs[PFPS_SLOT_PU_A][7:2] == 6'h00)
    else $error("unused bit stored in a two-bit register");

  AST_PU_A_HOLD: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R08
    !$rose(st.bvalid) |-> $stable(pad_ctrl_o.port_a_pullup))
    else $error("port A pull-ups changed without a write");

  AST_PU_B_HOLD: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R09
    !$rose(st.bvalid) |-> $stable(pad_ctrl_o.port_b_pullup))
    else $error("port B pull-ups changed without a write");

  AST_PU_C_HOLD: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R10
    !$rose(st.bvalid) |-> $stable(pad_ctrl_o.port_c_pullup))
    else $error("port C pull-ups changed without a write");

  AST_SNS_OTHERS: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R02
    $rose(st.bvalid) && !(st.wr_hit && st.wr_slot <= PFPS_SLOT_SNS_UPPER) |-> $stable(pad_ctrl_o.sensor_route))
    else $error("sensor routing changed by a write elsewhere");

  AST_ADC_OTHERS: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R04
    $rose(st.bvalid) && !(st.wr_hit && st.wr_slot >= PFPS_SLOT_ADC_LOW && st.wr_slot <= PFPS_SLOT_ADC_TOP)
      |-> $stable(pad_ctrl_o.analog_route))
    else $error("analog routing changed by a write elsewhere");

  AST_PU_OTHERS: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R11
    $rose(st.bvalid) && !(st.wr_hit && st.wr_slot >= PFPS_SLOT_PU_A) |->
      $stable({pad_ctrl_o.port_a_pullup, pad_ctrl_o.port_b_pullup, pad_ctrl_o.port_c_pullup}))
    else $error("pull-ups changed by a write elsewhere");

  AST_SNS_THIRD_ALONE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R01
    s_write_done(PFPS_SLOT_SNS_THIRD) |-> $stable(pad_ctrl_o.sensor_route[9:8]))
    else $error("write to channels 16-23 disturbed channels 24-25");

  AST_SNS_UPPER_ALONE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R03
    s_write_done(PFPS_SLOT_SNS_UPPER) |-> $stable(pad_ctrl_o.sensor_route[7:0]))
    else $error("write to channels 24-25 disturbed channels 16-23");

  AST_ADC_MID_ALONE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R06
    s_write_done(PFPS_SLOT_ADC_MID) |->
      $stable(pad_ctrl_o.analog_route[7:0]) && $stable(pad_ctrl_o.analog_route[25:16]))
    else $error("write to inputs 8-15 disturbed other analog inputs");

  AST_ADC_TOP_ALONE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R07
    s_write_done(PFPS_SLOT_ADC_TOP) |-> $stable(pad_ctrl_o.analog_route[23:0]))
    else $error("write to inputs 24-25 disturbed lower analog inputs");

endmodule // pfps_top

// ==== verif/tb_pad_function_pullup_select.sv ====
module tb_pad_function_pullup_select;
  timeunit 1ns;
  timeprecision 1ps;
  import pfps_pkg::*;

  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  pfps_pad_ctrl_t pad;
  logic [7:0] exp_reg [PFPS_NREG];
  int num_errors = 0;
  int n_tests = 0;

  always #2 sys_clk = ~sys_clk;

  pfps_top #(.ADDR_W(12)) uut (.sys_clk_i(sys_clk), .resetn_i(resetn),
    .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .pad_ctrl_o(pad));

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] expct);
    n_tests++;
    if (seen !== expct) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, expct, seen);
    end
  endtask

  task automatic stop_test;
    $display("Checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  function automatic logic [11:0] adr(input int i);
    adr = {2'b00, PFPS_IDX_TAB[i], 2'b00};
  endfunction

  // Expected pad controls rebuilt from the bench's own copy of the registers
  function automatic pfps_pad_ctrl_t exp_pad();
    exp_pad = {exp_reg[1][1:0], exp_reg[0], exp_reg[5][1:0], exp_reg[4], exp_reg[3], exp_reg[2],
      exp_reg[6][1:0], exp_reg[7], exp_reg[8]};
  endfunction

  // Each task starts one edge later so no bus signal is assigned twice in a time step
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    check("bvalid", bvalid, 1'b1);
    check("bresp", bresp, er);
    check("awready_busy", awready, 1'b0);
    check("wready_busy", wready, 1'b0);
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    check("rvalid", rvalid, 1'b1);
    check("arready_busy", arready, 1'b0);
    check("rdata", rdata, ed);
    check("rresp", rresp, er);
  endtask

  task automatic wr_reg(input int i, input logic [31:0] d);
    axi_wr(adr(i), d, 4'h1, PFPS_RESP_OKAY);
    exp_reg[i] = d[7:0] & PFPS_MASK_TAB[i];
    check("pad_ctrl", pad, exp_pad());
  endtask

  task automatic do_reset;
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    foreach (exp_reg[i]) exp_reg[i] = 8'h00;
    check("awready_reset", awready, 1'b1);
    check("wready_reset", wready, 1'b1);
    check("arready_reset", arready, 1'b1);
    check("bvalid_reset", bvalid, 1'b0);
    check("rvalid_reset", rvalid, 1'b0);
    for (int i = 0; i < PFPS_NREG; i++) axi_rd(adr(i), {24'h000000, PFPS_RST_TAB[i]}, PFPS_RESP_OKAY);
    check("pad_reset", pad, 64'h0);
    $display("Test reset done");
  endtask

  task automatic t_walk;
    for (int i = 0; i < PFPS_NREG; i++) begin
      for (int b = 0; b < 8; b++) begin
        wr_reg(i, 32'hFFFF_FF00 | (32'h1 << b));
        axi_rd(adr(i), {24'h000000, exp_reg[i]}, PFPS_RESP_OKAY);
      end
      wr_reg(i, 32'h0000_0000);
    end
    $display("Test walk done");
  endtask

  task automatic t_multi;
    for (int i = 0; i < PFPS_NREG; i++) wr_reg(i, 32'h0000_00FF);
    check("pad_all", pad, {54{1'b1}});
    wr_reg(1, 32'h0000_0002);
    wr_reg(5, 32'h0000_0001);
    wr_reg(3, 32'h0000_00A5);
    for (int i = 0; i < PFPS_NREG; i++) axi_rd(adr(i), {24'h000000, exp_reg[i]}, PFPS_RESP_OKAY);
    $display("Test multi done");
  endtask

  // Stored values stay put across refused or strobe-less writes
  task automatic t_refuse;
    axi_wr(12'h35C, 32'h0000_0000, 4'h1, PFPS_RESP_SLVERR);
    axi_wr(12'h355, 32'h0000_0000, 4'h1, PFPS_RESP_SLVERR);
    axi_wr(adr(7), 32'h0000_0000, 4'h0, PFPS_RESP_OKAY);
    check("pad_refused", pad, exp_pad());
    axi_rd(12'h000, 32'h0000_0000, PFPS_RESP_SLVERR);
    axi_rd(adr(7), {24'h000000, exp_reg[7]}, PFPS_RESP_OKAY);
    $display("Test refuse done");
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    stop_test();
  end

  initial begin
    do_reset();
    t_walk();
    t_multi();
    t_refuse();
    do_reset();
    stop_test();
  end
endmodule // tb_pad_function_pullup_select
